// File: core/stid_defines.vh
// Constants of the skip-test instruction decoder
`ifndef STID_DEFINES_VH
`define STID_DEFINES_VH

`define STID_OP_W 10
`define STID_DATA_W 4
`define STID_ADDR_W 4

`define STID_OP_CONV_DONE 10'h287
`define STID_OP_PIN_LEVEL 10'h03A
`define STID_OP_POWERDOWN 10'h003

`define STID_ADDR_IC1 4'h0
`define STID_ADDR_IC2 4'h1
`define STID_ADDR_FLAGS 4'h2
`define STID_ADDR_STATUS 4'h3
`define STID_ADDR_MASK 4'h4

`define STID_BIT_POLARITY 2
`define STID_BIT_CONV_IRQ_EN 2

`define STID_FLAG_CONV 0
`define STID_FLAG_PDOWN 1
`define STID_FLAG_PIN 2

`define STID_EVT_N 3
`define STID_EVT_CONV_SET 0
`define STID_EVT_SKIP 1
`define STID_EVT_SQUASH 2

`define STID_RST_REG 4'h0
`define STID_RST_OP 10'h000

`endif

// File: core/stid_sync.v
// Two-stage synchroniser for an external pin level
`include "stid_defines.vh"

module stid_sync (
   input wire clk_sys_i,
   input wire rst_i,
   input wire async_i,
   output wire sync_o
);

   reg meta_q;
   reg sync_q;

   // First stage feeds only the second stage
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // stid_sync

// File: core/stid_decode.v
// Opcode decoder for the three skip-test instructions
`include "stid_defines.vh"

module stid_decode (
   input wire [`STID_OP_W-1:0] op_i,
   output wire sel_conv_o,
   output wire sel_pin_o,
   output wire sel_pdown_o
);

   function is_op;
      input [`STID_OP_W-1:0] op;
      input [`STID_OP_W-1:0] code;
      begin
         is_op = (op == code);
      end
   endfunction

   assign sel_conv_o = is_op(op_i, `STID_OP_CONV_DONE);
   assign sel_pin_o = is_op(op_i, `STID_OP_PIN_LEVEL);
   assign sel_pdown_o = is_op(op_i, `STID_OP_POWERDOWN);

endmodule // stid_decode

// File: core/stid_core.v
// Skip-test instruction decode and execute unit with register port
//
// The register addresses and strobed register access are this design's own decisions.
`include "stid_defines.vh"

module stid_core (
   input wire clk_sys_i,
   input wire rst_i,
   // Instruction stream from the sequencer
   input wire instr_valid_i,
   input wire [`STID_OP_W-1:0] instr_i,
   // Peripheral flags
   input wire conv_done_set_i,
   input wire powerdown_flag_i,
   input wire ext_int_pin_i,
   // Register port
   input wire [`STID_ADDR_W-1:0] reg_addr_i,
   input wire [`STID_DATA_W-1:0] reg_wdata_i,
   input wire reg_we_i,
   input wire reg_re_i,
   output wire [`STID_DATA_W-1:0] reg_rdata_o,
   // Execute stage
   output wire exec_valid_o,
   output wire [`STID_OP_W-1:0] exec_instr_o,
   output wire exec_squash_o,
   output wire skip_next_o,
   output wire carry_we_o,
   output wire conv_done_flag_o,
   output wire irq_o
);

   // Register state
   reg [`STID_DATA_W-1:0] interrupt_control_one_q;
   reg [`STID_DATA_W-1:0] interrupt_control_two_q;
   reg [`STID_DATA_W-1:0] irq_status_q;
   reg [`STID_DATA_W-1:0] irq_mask_q;
   reg [`STID_DATA_W-1:0] rdata_q;
   reg [`STID_DATA_W-1:0] rdata_d;

   // Execute state
   reg conversion_done_flag_q;
   reg conversion_done_flag_d;
   reg skip_pending_q;
   reg skip_pending_d;
   reg exec_valid_q;
   reg [`STID_OP_W-1:0] exec_instr_q;
   reg exec_squash_q;
   reg irq_q;

   // Next values of registered state
   reg [`STID_DATA_W-1:0] interrupt_control_one_d;
   reg [`STID_DATA_W-1:0] interrupt_control_two_d;
   reg [`STID_DATA_W-1:0] irq_mask_d;
   reg exec_valid_d;
   reg [`STID_OP_W-1:0] exec_instr_d;
   reg exec_squash_d;
   reg irq_d;

   // Decode and conditions
   wire sel_conv;
   wire sel_pin;
   wire sel_pdown;
   wire pin_level;
   wire polarity_sel;
   wire conv_irq_en;
   wire live_instr;
   wire squash_now;
   reg take_skip;
   reg clear_conv;

   // Events
   wire [`STID_EVT_N-1:0] evt;
   wire [`STID_DATA_W-1:0] status_clr;

   // Register port decode
   wire we_ic1;
   wire we_ic2;
   wire we_status;
   wire we_mask;

   // Read-only flag word
   wire [`STID_DATA_W-1:0] flags_word;

   // Pin level brought into the clock domain
   stid_sync u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i(ext_int_pin_i),
      .sync_o(pin_level)
   );

   // Opcode decoder
   stid_decode u_decode (
      .op_i(instr_i),
      .sel_conv_o(sel_conv),
      .sel_pin_o(sel_pin),
      .sel_pdown_o(sel_pdown)
   );

   // Control bit taps
   assign polarity_sel = interrupt_control_one_q[`STID_BIT_POLARITY];
   assign conv_irq_en = interrupt_control_two_q[`STID_BIT_CONV_IRQ_EN];

   // An instruction behind a taken skip is dropped
   assign squash_now = instr_valid_i & skip_pending_q;
   assign live_instr = instr_valid_i & ~skip_pending_q;

   // Skip condition evaluation
   always @* begin
      take_skip = 1'b0;
      clear_conv = 1'b0;
      if (live_instr) begin
         if (sel_conv) begin
            if (!conv_irq_en) begin
               take_skip = conversion_done_flag_q;
               clear_conv = conversion_done_flag_q;
            end else begin
               take_skip = 1'b0;
               clear_conv = 1'b0;
            end
         end else if (sel_pin) begin
            if (polarity_sel) begin
               take_skip = pin_level;
            end else begin
               take_skip = ~pin_level;
            end
         end else if (sel_pdown) begin
            take_skip = powerdown_flag_i;
         end
      end
   end

   // Conversion flag: a new completion wins over a clear in the same cycle
   always @* begin
      conversion_done_flag_d = conversion_done_flag_q;
      if (clear_conv) begin
         conversion_done_flag_d = 1'b0;
      end
      if (conv_done_set_i) begin
         conversion_done_flag_d = 1'b1;
      end
   end

   // Skip marker covers exactly the next instruction
   always @* begin
      skip_pending_d = skip_pending_q;
      if (squash_now) begin
         skip_pending_d = 1'b0;
      end else if (take_skip) begin
         skip_pending_d = 1'b1;
      end
   end

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         conversion_done_flag_q <= 1'b0;
         skip_pending_q <= 1'b0;
      end else begin
         conversion_done_flag_q <= conversion_done_flag_d;
         skip_pending_q <= skip_pending_d;
      end
   end

   // Next values of the execute stage; a dropped word shows as zero
   always @* begin
      exec_valid_d = live_instr;
      exec_squash_d = squash_now;
      exec_instr_d = `STID_RST_OP;
      if (live_instr) begin
         exec_instr_d = instr_i;
      end
   end

   // Execute stage outputs, one instruction cycle per word
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         exec_valid_q <= 1'b0;
         exec_instr_q <= `STID_RST_OP;
         exec_squash_q <= 1'b0;
      end else begin
         exec_valid_q <= exec_valid_d;
         exec_squash_q <= exec_squash_d;
         exec_instr_q <= exec_instr_d;
      end
   end

   // Address match for one register of the port
   function addr_hit;
      input [`STID_ADDR_W-1:0] addr;
      input [`STID_ADDR_W-1:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // Write decode
   assign we_ic1 = reg_we_i & addr_hit(reg_addr_i, `STID_ADDR_IC1);
   assign we_ic2 = reg_we_i & addr_hit(reg_addr_i, `STID_ADDR_IC2);
   assign we_status = reg_we_i & addr_hit(reg_addr_i, `STID_ADDR_STATUS);
   assign we_mask = reg_we_i & addr_hit(reg_addr_i, `STID_ADDR_MASK);

   // Next values of the control registers
   always @* begin
      interrupt_control_one_d = interrupt_control_one_q;
      interrupt_control_two_d = interrupt_control_two_q;
      irq_mask_d = irq_mask_q;
      if (we_ic1) begin
         interrupt_control_one_d = reg_wdata_i;
      end
      if (we_ic2) begin
         interrupt_control_two_d = reg_wdata_i;
      end
      if (we_mask) begin
         irq_mask_d = reg_wdata_i;
      end
   end

   // Interrupt control registers
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         interrupt_control_one_q <= `STID_RST_REG;
         interrupt_control_two_q <= `STID_RST_REG;
         irq_mask_q <= `STID_RST_REG;
      end else begin
         interrupt_control_one_q <= interrupt_control_one_d;
         interrupt_control_two_q <= interrupt_control_two_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // Events that raise status bits
   assign evt[`STID_EVT_CONV_SET] = conv_done_set_i;
   assign evt[`STID_EVT_SKIP] = take_skip;
   assign evt[`STID_EVT_SQUASH] = squash_now;
   assign status_clr = we_status ? reg_wdata_i : `STID_RST_REG;

   // Sticky status, write one to clear, set wins
   genvar gi;
   generate
      for (gi = 0; gi < `STID_EVT_N; gi = gi + 1) begin : g_status
         always @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               irq_status_q[gi] <= 1'b0;
            end else if (evt[gi]) begin
               irq_status_q[gi] <= 1'b1;
            end else if (status_clr[gi]) begin
               irq_status_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Unused top status bit
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         irq_status_q[`STID_DATA_W-1] <= 1'b0;
      end else begin
         irq_status_q[`STID_DATA_W-1] <= 1'b0;
      end
   end

   // Level interrupt from unmasked status
   always @* begin
      irq_d = |(irq_status_q & irq_mask_q);
   end

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // Read-only flag word, top bit unused
   assign flags_word[`STID_FLAG_CONV] = conversion_done_flag_q;
   assign flags_word[`STID_FLAG_PDOWN] = powerdown_flag_i;
   assign flags_word[`STID_FLAG_PIN] = pin_level;
   assign flags_word[`STID_DATA_W-1] = 1'b0;

   // Read mux
   always @* begin
      rdata_d = `STID_RST_REG;
      if (reg_re_i) begin
         case (reg_addr_i)
            `STID_ADDR_IC1: begin
               rdata_d = interrupt_control_one_q;
            end
            `STID_ADDR_IC2: begin
               rdata_d = interrupt_control_two_q;
            end
            `STID_ADDR_FLAGS: begin
               rdata_d = flags_word;
            end
            `STID_ADDR_STATUS: begin
               rdata_d = irq_status_q;
            end
            `STID_ADDR_MASK: begin
               rdata_d = irq_mask_q;
            end
            default: begin
               rdata_d = `STID_RST_REG;
            end
         endcase
      end
   end

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= `STID_RST_REG;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs
   assign reg_rdata_o = rdata_q;
   assign exec_valid_o = exec_valid_q;
   assign exec_instr_o = exec_instr_q;
   assign exec_squash_o = exec_squash_q;
   assign skip_next_o = skip_pending_q;
   assign conv_done_flag_o = conversion_done_flag_q;
   assign irq_o = irq_q;
   // Skip tests never write carry
   assign carry_we_o = 1'b0;

endmodule // stid_core

// File: sim/stid_core_assertions.sv
// Concurrent checks on the ports of the skip-test decode unit
`include "stid_defines.vh"
module stid_checker (
   input logic clk_sys_i,
   input logic rst_i,
   input logic instr_valid_i,
   input logic [`STID_OP_W-1:0] instr_i,
   input logic conv_done_set_i,
   input logic powerdown_flag_i,
   input logic ext_int_pin_i,
   input logic [`STID_ADDR_W-1:0] reg_addr_i,
   input logic [`STID_DATA_W-1:0] reg_wdata_i,
   input logic reg_we_i,
   input logic exec_valid_o,
   input logic [`STID_OP_W-1:0] exec_instr_o,
   input logic exec_squash_o,
   input logic skip_next_o,
   input logic carry_we_o,
   input logic conv_done_flag_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ic1_q, ic2_q, s1_q, s2_q;
   wire go = instr_valid_i && !skip_next_o;
   // Mirror of the control bits and of the pin synchroniser
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         {ic1_q, ic2_q, s1_q, s2_q} <= 4'h0;
      end else begin
         s1_q <= ext_int_pin_i;
         s2_q <= s1_q;
         if (reg_we_i && reg_addr_i == `STID_ADDR_IC1) ic1_q <= reg_wdata_i[2];
         if (reg_we_i && reg_addr_i == `STID_ADDR_IC2) ic2_q <= reg_wdata_i[2];
      end
   end
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   a_carry_kept: assert property (carry_we_o == 1'b0)
      else $error("carry write raised");
   a_word_executes: assert property (go |=> exec_valid_o && exec_instr_o == $past(instr_i))
      else $error("word not executed");
   a_word_dropped: assert property (instr_valid_i && skip_next_o
      |=> exec_squash_o && !exec_valid_o && !skip_next_o)
      else $error("word not dropped");
   a_skip_holds: assert property (skip_next_o && !instr_valid_i |=> skip_next_o)
      else $error("skip lost");
   a_conv_skip: assert property (go && instr_i == `STID_OP_CONV_DONE && !ic2_q && !conv_done_set_i
      |=> skip_next_o == $past(conv_done_flag_o) && !conv_done_flag_o)
      else $error("conversion skip wrong");
   a_conv_nop: assert property (go && instr_i == `STID_OP_CONV_DONE && ic2_q
      |=> !skip_next_o && (conv_done_flag_o || !$past(conv_done_flag_o)))
      else $error("conversion nop wrong");
   a_pin_skip: assert property (go && instr_i == `STID_OP_PIN_LEVEL
      |=> skip_next_o == ($past(s2_q) == $past(ic1_q)))
      else $error("pin skip wrong");
   a_pdown_skip: assert property (go && instr_i == `STID_OP_POWERDOWN
      |=> skip_next_o == $past(powerdown_flag_i))
      else $error("power-down skip wrong");
   c_conv: cover property (go && instr_i == `STID_OP_CONV_DONE ##1 skip_next_o);
   c_pin: cover property (go && instr_i == `STID_OP_PIN_LEVEL ##1 skip_next_o);
   c_drop: cover property (exec_squash_o);
endmodule // stid_checker

bind stid_core stid_checker chk_u (.clk_sys_i, .rst_i, .instr_valid_i, .instr_i, .conv_done_set_i,
   .powerdown_flag_i, .ext_int_pin_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .exec_valid_o,
   .exec_instr_o, .exec_squash_o, .skip_next_o, .carry_we_o, .conv_done_flag_o);

// File: sim/testbench.sv
// Self-checking bench for the skip-test decode unit
`include "stid_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, iv = 1'b0, cds = 1'b0, pd = 1'b0, pin = 1'b0;
   logic we = 1'b0, re = 1'b0;
   logic [9:0] op = 10'h000;
   logic [3:0] addr = 4'h0, wd = 4'h0, v;
   wire [3:0] rd;
   wire [9:0] ei;
   wire ev, sq, sk, cwe, flag, irq;
   int num_errors = 0, checks = 0, cycles = 0;
   stid_core dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_valid_i(iv), .instr_i(op),
      .conv_done_set_i(cds), .powerdown_flag_i(pd), .ext_int_pin_i(pin), .reg_addr_i(addr),
      .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rd), .exec_valid_o(ev),
      .exec_instr_o(ei), .exec_squash_o(sq), .skip_next_o(sk), .carry_we_o(cwe),
      .conv_done_flag_o(flag), .irq_o(irq));
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      if (num_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [3:0] d);
      @(posedge clk_sys_i);
      we <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk_sys_i);
      we <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a);
      @(posedge clk_sys_i);
      re <= 1'b1;
      addr <= a;
      @(posedge clk_sys_i);
      re <= 1'b0;
      #1 v = rd;
   endtask
   task automatic pulse_conv;
      @(posedge clk_sys_i);
      cds <= 1'b1;
      @(posedge clk_sys_i);
      cds <= 1'b0;
      #1 check(flag, 1'b1);
   endtask
   // Offers one word, then a filler that must be dropped when a skip is due
   task automatic issue(input logic [9:0] o, input logic s);
      @(posedge clk_sys_i);
      iv <= 1'b1;
      op <= o;
      @(posedge clk_sys_i);
      iv <= 1'b0;
      #1 check({ev, cwe, sk}, {2'b10, s});
      check(ei, o);
      if (s) begin
         @(posedge clk_sys_i);
         iv <= 1'b1;
         op <= 10'h155;
         @(posedge clk_sys_i);
         iv <= 1'b0;
         #1 check({sq, ev, sk}, 3'b100);
      end
   endtask
   task automatic t_conv;
      reg_wr(`STID_ADDR_IC2, 4'h0);
      pulse_conv;
      issue(`STID_OP_CONV_DONE, 1'b1);
      check(flag, 1'b0);
      issue(`STID_OP_CONV_DONE, 1'b0);
      reg_wr(`STID_ADDR_IC2, 4'h4);
      pulse_conv;
      issue(`STID_OP_CONV_DONE, 1'b0);
      check(flag, 1'b1);
      reg_rd(`STID_ADDR_IC2);
      check(v, 4'h4);
      issue(10'h286, 1'b0);
      reg_wr(`STID_ADDR_IC2, 4'hB);
      issue(`STID_OP_CONV_DONE, 1'b1);
      pulse_conv;
   endtask
   task automatic t_pin;
      for (int k = 0; k < 4; k++) begin
         reg_wr(`STID_ADDR_IC1, k[1] ? 4'h4 : 4'hB);
         pin <= k[0];
         repeat (3) @(posedge clk_sys_i);
         issue(`STID_OP_PIN_LEVEL, k[0] == k[1]);
         issue(10'h03B, 1'b0);
      end
      reg_rd(`STID_ADDR_IC1);
      check(v, 4'h4);
   endtask
   task automatic t_pdown;
      @(posedge clk_sys_i);
      pd <= 1'b1;
      issue(`STID_OP_POWERDOWN, 1'b1);
      issue(`STID_OP_POWERDOWN, 1'b1);
      issue(10'h013, 1'b0);
      pd <= 1'b0;
      issue(`STID_OP_POWERDOWN, 1'b0);
   endtask
   task automatic t_irq;
      reg_wr(`STID_ADDR_STATUS, 4'hF);
      reg_wr(`STID_ADDR_MASK, 4'h0);
      pulse_conv;
      reg_rd(`STID_ADDR_STATUS);
      check({irq, v}, 5'h01);
      reg_wr(`STID_ADDR_MASK, 4'h1);
      @(posedge clk_sys_i);
      #1 check(irq, 1'b1);
      reg_wr(`STID_ADDR_STATUS, 4'h1);
      @(posedge clk_sys_i);
      #1 check(irq, 1'b0);
      reg_wr(`STID_ADDR_FLAGS, 4'h0);
      reg_rd(`STID_ADDR_FLAGS);
      check(v, 4'h5);
      reg_rd(4'h7);
      check(v, 4'h0);
   endtask
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         complete_run;
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_conv;
      t_pin;
      t_pdown;
      t_irq;
      complete_run;
   end
endmodule // testbench
